// >>> logic/acq_cfg.svh
// Functional notes
// - single-shot: one capture and one scan pass per accepted external trigger
// - single-shot and gated scans are bounded by the scan time limit
// - continuous: internal timing starts captures; read on success, else recapture
// - continuous mode never reports a no-read
// - continuous: same code suppressed until reject interval elapses since its report
// - continuous: a different code is reported at once
// - gated: capture and scan while input active; stop on read or inactive
// - gated: no no-read while the trigger input stays active
// - command mode: each serial or ethernet trigger command starts a capture
// - trigger mode is writable from the host command channel as well
// - industrial ethernet triggers ignored in continuous mode
// - industrial-ethernet-only mode accepts only industrial ethernet triggers
// - external strobe: on, off, or asserted only during capture
// - ring light: on, off, or asserted only during capture
// - ultraviolet variants never allow ring light permanently on
// - failed-image display hold programmable from 0 to 3600 seconds
// - display hold affects only the display, never trigger acceptance
// - full view by default and restored by the restore_full_view command
// - external trigger detected on one edge chosen by polarity
// - trigger while busy sets missed-trigger, except in gated mode, until history is cleared
`ifndef ACQ_CFG_SVH
`define ACQ_CFG_SVH
// register offsets
`define ACQ_REG_CTRL 4'h0
`define ACQ_REG_STROBE 4'h1
`define ACQ_REG_SCAN_LIMIT 4'h2
`define ACQ_REG_REJECT 4'h3
`define ACQ_REG_HOLD 4'h4
`define ACQ_REG_CAPTURE 4'h5
`define ACQ_REG_STATUS 4'h6
`define ACQ_REG_CMD 4'h7
`define ACQ_REG_LAST_CODE 4'h8
`define ACQ_REG_VIEW 4'h9
// control fields
`define ACQ_CTRL_MODE_LSB 0
`define ACQ_CTRL_POL_BIT 3
`define ACQ_STROBE_EXT_LSB 0
`define ACQ_STROBE_RING_LSB 2
// command bits
`define ACQ_CMD_CLEAR_HIST 0
`define ACQ_CMD_RESTORE_VIEW 1
// reset values
`define ACQ_MODE_RST 3'h1
`define ACQ_SCAN_LIMIT_RST 16'h03e8
`define ACQ_REJECT_RST 16'h0001
`define ACQ_HOLD_RST 12'h000
`define ACQ_CAPTURE_RST 16'h0064
`define ACQ_HOLD_MAX 12'he10
`define ACQ_FULL_VIEW 32'hffff_ffff
// timing: one millisecond and one second tick
`define ACQ_CLK_HZ 50000000
`define ACQ_MS_CYCLES (`ACQ_CLK_HZ / 1000)
`define ACQ_SEC_MS 1000
`endif

// >>> logic/acq_pkg.sv
package acq_pkg;
   typedef enum logic [2:0] {
      mode_continuous = 3'h0,
      mode_single = 3'h1,
      mode_gated = 3'h2,
      mode_command = 3'h3,
      mode_ie_only = 3'h4
   } trig_mode_e;
   typedef enum logic [1:0] {
      light_off = 2'h0,
      light_on = 2'h1,
      light_exposure = 2'h2
   } light_mode_e;
   typedef enum logic [4:0] {
      st_idle = 5'b00001,
      st_capture = 5'b00010,
      st_scan = 5'b00100,
      st_report = 5'b01000,
      st_noread = 5'b10000
   } acq_state_e;
endpackage : acq_pkg

// >>> logic/tick_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "acq_cfg.svh"
// millisecond and second ticks shared by every timer of the sequencer
module tick_divider (
   input wire logic clk,
   input wire logic reset,
   output logic ms_tick,
   output logic sec_tick
);
   typedef struct packed {
      logic [15:0] div;
      logic [9:0] ms;
      logic ms_tick;
      logic sec_tick;
   } tick_s;
   tick_s r;
   tick_s next_r;
   // ==========================================
   // next state
   always_comb begin
      next_r = r;
      next_r.ms_tick = 1'b0;
      next_r.sec_tick = 1'b0;
      if (r.div == 16'(`ACQ_MS_CYCLES - 1)) begin
         next_r.div = 16'h0000;
         next_r.ms_tick = 1'b1;
         if (r.ms == 10'(`ACQ_SEC_MS - 1)) begin
            next_r.ms = 10'h000;
            next_r.sec_tick = 1'b1;
         end else begin
            next_r.ms = r.ms + 10'h001;
         end
      end else begin
         next_r.div = r.div + 16'h0001;
      end
   end
   // registers
   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign ms_tick = r.ms_tick;
   assign sec_tick = r.sec_tick;
endmodule : tick_divider
`default_nettype wire

// >>> logic/acq_trigger_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "acq_cfg.svh"
// trigger selection, capture sequencing, duplicate rejection and light drive
module acq_trigger_ctrl #(
   parameter bit UV_VARIANT = 1'b0
) (
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // trigger sources
   input wire logic ext_trigger,
   input wire logic host_trigger,
   input wire logic host_mode_write,
   input wire logic [2:0] host_mode,
   input wire logic ie_trigger,
   // decoder side
   input wire logic scan_done,
   input wire logic scan_found,
   input wire logic [31:0] scan_code,
   output logic capture_active,
   output logic scan_start,
   output logic read_event,
   output logic noread_event,
   output logic [31:0] report_code,
   output logic missed_trigger,
   output logic display_hold,
   output logic ext_strobe,
   output logic ring_light,
   output logic [31:0] view_window
);
   typedef struct packed {
      acq_pkg::acq_state_e state;
      // software settings
      acq_pkg::trig_mode_e mode;
      logic polarity;
      acq_pkg::light_mode_e ext_light;
      acq_pkg::light_mode_e ring_mode;
      logic [15:0] scan_limit;
      logic [15:0] reject_sec;
      logic [11:0] hold_sec;
      logic [15:0] capture_ms;
      logic [31:0] view;
      // timers, last report and flags
      logic trig_prev;
      logic [15:0] ms_cnt;
      logic [15:0] rej_cnt;
      logic rej_live;
      logic [31:0] last_code;
      logic have_code;
      logic [11:0] hold_cnt;
      logic hold;
      logic missed;
      // registered outputs
      logic cap;
      logic start;
      logic rd;
      logic nr;
      logic [31:0] code;
      logic strobe;
      logic ring;
      logic [31:0] rdata;
   } ctrl_s;
   ctrl_s r;
   ctrl_s next_r;
   logic ms_tick;
   logic sec_tick;
   logic edge_hit;
   logic accept;
   logic busy;
   logic gate_level;

   // one divider feeds every timer
   tick_divider u_tick (
      .clk(clk),
      .reset(reset),
      .ms_tick(ms_tick),
      .sec_tick(sec_tick)
   );

   // light drive from the chosen setting and the capture window
   function automatic logic light_level(input acq_pkg::light_mode_e m, input logic cap);
      case (m)
         acq_pkg::light_on: light_level = 1'b1;
         acq_pkg::light_exposure: light_level = cap;
         default: light_level = 1'b0;
      endcase
   endfunction : light_level

   // ring setting with the permanently-on choice refused on uv parts
   function automatic acq_pkg::light_mode_e ring_filter(input logic [1:0] v);
      if (v == acq_pkg::light_on && UV_VARIANT) begin
         ring_filter = acq_pkg::light_off;
      end else if (v > 2'h2) begin
         // code 3 is undefined; the ring stays dark
         ring_filter = acq_pkg::light_off;
      end else begin
         ring_filter = acq_pkg::light_mode_e'(v);
      end
   endfunction : ring_filter

   // only defined mode codes are taken; others keep the current mode
   function automatic logic mode_ok(input logic [2:0] v);
      mode_ok = (v <= 3'h4);
   endfunction : mode_ok

   // ==========================================
   // trigger qualification
   always_comb begin
      gate_level = ext_trigger ~^ r.polarity; // level that counts as active
      edge_hit = gate_level && !(r.trig_prev ~^ r.polarity);
      busy = (r.state != acq_pkg::st_idle);
      // refused sources never count as triggers
      case (r.mode)
         acq_pkg::mode_single: accept = edge_hit;
         acq_pkg::mode_gated: accept = edge_hit;
         acq_pkg::mode_command: accept = host_trigger || ie_trigger;
         acq_pkg::mode_ie_only: accept = ie_trigger;
         default: accept = 1'b0;
      endcase
   end

   // ==========================================
   // next state
   always_comb begin
      next_r = r;
      next_r.trig_prev = ext_trigger;
      next_r.start = 1'b0;
      next_r.rd = 1'b0;
      next_r.nr = 1'b0;
      next_r.rdata = 32'h0000_0000;

      // millisecond count shared by capture and scan
      if (ms_tick) begin
         next_r.ms_cnt = r.ms_cnt + 16'h0001;
      end

      // reject interval, seconds since the last report
      if (sec_tick && r.rej_live) begin
         if (r.rej_cnt + 16'h0001 >= r.reject_sec) begin
            next_r.rej_live = 1'b0;
         end
         next_r.rej_cnt = r.rej_cnt + 16'h0001;
      end

      // display hold runs on its own; it never touches the sequencer
      if (sec_tick && r.hold) begin
         if (r.hold_cnt == 12'h000) begin
            next_r.hold = 1'b0;
         end else begin
            next_r.hold_cnt = r.hold_cnt - 12'h001;
         end
      end

      // outside gated mode, a trigger arriving mid-inspection is flagged, not queued
      if (busy && accept && r.mode != acq_pkg::mode_gated) begin
         next_r.missed = 1'b1;
      end

      // sequencer
      case (r.state)
         // wait for an accepted trigger; continuous needs none
         acq_pkg::st_idle: begin
            if (r.mode == acq_pkg::mode_continuous || accept) begin
               next_r.state = acq_pkg::st_capture;
               next_r.ms_cnt = 16'h0000;
               next_r.cap = 1'b1;
            end
         end
         // light window open for capture_ms millisecond ticks
         acq_pkg::st_capture: begin
            if (ms_tick && r.ms_cnt + 16'h0001 >= r.capture_ms) begin
               next_r.cap = 1'b0;
               next_r.start = 1'b1; // one pass per image
               next_r.ms_cnt = 16'h0000;
               next_r.state = acq_pkg::st_scan;
            end
         end
         // one pass; a timeout counts as a failed pass
         acq_pkg::st_scan: begin
            if (scan_done && scan_found) begin
               next_r.state = acq_pkg::st_report;
            end else if (scan_done || (ms_tick && r.ms_cnt + 16'h0001 >= r.scan_limit)) begin
               next_r.state = acq_pkg::st_noread;
            end
         end
         // continuous mode filters repeats of the last code
         acq_pkg::st_report: begin
            next_r.state = acq_pkg::st_idle;
            if (r.mode == acq_pkg::mode_continuous) begin
               if (!(r.have_code && r.rej_live && scan_code == r.last_code)) begin
                  next_r.rd = 1'b1;
                  next_r.code = scan_code;
                  next_r.last_code = scan_code;
                  next_r.have_code = 1'b1;
                  next_r.rej_live = (r.reject_sec != 16'h0000);
                  next_r.rej_cnt = 16'h0000;
               end
            end else begin
               // other modes report every found code
               next_r.rd = 1'b1;
               next_r.code = scan_code;
               next_r.last_code = scan_code;
               next_r.have_code = 1'b1;
            end
         end
         // continuous and gated-active retry instead of reporting
         acq_pkg::st_noread: begin
            if (r.mode == acq_pkg::mode_continuous) begin
               next_r.state = acq_pkg::st_capture;
               next_r.cap = 1'b1;
               next_r.ms_cnt = 16'h0000;
            end else if (r.mode == acq_pkg::mode_gated && gate_level) begin
               next_r.state = acq_pkg::st_capture;
               next_r.cap = 1'b1;
               next_r.ms_cnt = 16'h0000;
            end else begin
               next_r.state = acq_pkg::st_idle;
               next_r.nr = 1'b1;
               next_r.hold = 1'b1;
               next_r.hold_cnt = r.hold_sec;
            end
         end
         default: begin
            next_r.state = acq_pkg::st_idle;
            next_r.cap = 1'b0;
         end
      endcase

      // gated attempt abandoned when the input drops
      if (r.mode == acq_pkg::mode_gated && !gate_level
            && (r.state == acq_pkg::st_capture || r.state == acq_pkg::st_scan)) begin
         next_r.state = acq_pkg::st_noread;
         next_r.cap = 1'b0;
      end

      // host mode change from the command channel
      if (host_mode_write && mode_ok(host_mode)) begin
         next_r.mode = acq_pkg::trig_mode_e'(host_mode);
      end

      // register writes
      if (reg_write) begin
         case (reg_addr)
            `ACQ_REG_CTRL: begin
               if (mode_ok(reg_wdata[`ACQ_CTRL_MODE_LSB +: 3])) begin
                  next_r.mode = acq_pkg::trig_mode_e'(reg_wdata[`ACQ_CTRL_MODE_LSB +: 3]);
               end
               next_r.polarity = reg_wdata[`ACQ_CTRL_POL_BIT];
            end
            `ACQ_REG_STROBE: begin
               if (reg_wdata[`ACQ_STROBE_EXT_LSB +: 2] <= 2'h2) begin
                  next_r.ext_light = acq_pkg::light_mode_e'(reg_wdata[`ACQ_STROBE_EXT_LSB +: 2]);
               end
               next_r.ring_mode = ring_filter(reg_wdata[`ACQ_STROBE_RING_LSB +: 2]);
            end
            `ACQ_REG_SCAN_LIMIT: next_r.scan_limit = reg_wdata[15:0];
            `ACQ_REG_REJECT: next_r.reject_sec = reg_wdata[15:0];
            `ACQ_REG_HOLD: begin
               // values past the top of the range are clamped
               next_r.hold_sec = (reg_wdata[11:0] > `ACQ_HOLD_MAX || reg_wdata[31:12] != 20'h0)
                  ? `ACQ_HOLD_MAX : reg_wdata[11:0];
            end
            `ACQ_REG_CAPTURE: next_r.capture_ms = reg_wdata[15:0];
            `ACQ_REG_CMD: begin
               // both commands may share one write
               if (reg_wdata[`ACQ_CMD_CLEAR_HIST]) begin
                  next_r.missed = 1'b0;
               end
               if (reg_wdata[`ACQ_CMD_RESTORE_VIEW]) begin
                  next_r.view = `ACQ_FULL_VIEW;
               end
            end
            `ACQ_REG_VIEW: next_r.view = reg_wdata;
            default: begin
            end
         endcase
         // a miss in the clearing cycle survives the clear
         if (reg_addr == `ACQ_REG_CMD && reg_wdata[`ACQ_CMD_CLEAR_HIST] && busy && accept
               && r.mode != acq_pkg::mode_gated) begin
            next_r.missed = 1'b1;
         end
      end

      // register reads, data in the following cycle
      if (reg_read) begin
         case (reg_addr)
            `ACQ_REG_CTRL: next_r.rdata = {28'h0, r.polarity, r.mode};
            `ACQ_REG_STROBE: next_r.rdata = {28'h0, r.ring_mode, r.ext_light};
            `ACQ_REG_SCAN_LIMIT: next_r.rdata = {16'h0, r.scan_limit};
            `ACQ_REG_REJECT: next_r.rdata = {16'h0, r.reject_sec};
            `ACQ_REG_HOLD: next_r.rdata = {20'h0, r.hold_sec};
            `ACQ_REG_CAPTURE: next_r.rdata = {16'h0, r.capture_ms};
            `ACQ_REG_STATUS: next_r.rdata = {24'h0, r.hold, r.missed, r.rej_live, r.state};
            `ACQ_REG_LAST_CODE: next_r.rdata = r.last_code;
            `ACQ_REG_VIEW: next_r.rdata = r.view;
            default: next_r.rdata = 32'h0000_0000;
         endcase
      end

      // light outputs follow the registered capture window
      next_r.strobe = light_level(next_r.ext_light, next_r.cap);
      next_r.ring = light_level(next_r.ring_mode, next_r.cap);
   end

   // ==========================================
   // registers
   always_ff @(posedge clk) begin
      if (reset) begin
         // settings take their defaults; the rest clears
         r <= '0;
         r.state <= acq_pkg::st_idle;
         r.mode <= acq_pkg::trig_mode_e'(`ACQ_MODE_RST);
         r.ext_light <= acq_pkg::light_exposure;
         r.ring_mode <= acq_pkg::light_exposure;
         r.scan_limit <= `ACQ_SCAN_LIMIT_RST;
         r.reject_sec <= `ACQ_REJECT_RST;
         r.hold_sec <= `ACQ_HOLD_RST;
         r.capture_ms <= `ACQ_CAPTURE_RST;
         r.view <= `ACQ_FULL_VIEW;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state register
   assign reg_rdata = r.rdata;
   assign capture_active = r.cap;
   assign scan_start = r.start;
   assign read_event = r.rd;
   assign noread_event = r.nr;
   assign report_code = r.code;
   assign missed_trigger = r.missed;
   assign display_hold = r.hold;
   assign ext_strobe = r.strobe;
   assign ring_light = r.ring;
   assign view_window = r.view;
endmodule : acq_trigger_ctrl
`default_nettype wire

// >>> verif/acq_trigger_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// port-level checks of the trigger sequencer
module acq_trigger_ctrl_chk (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic ie_trigger,
   input wire logic scan_done,
   input wire logic scan_found,
   input wire logic capture_active,
   input wire logic scan_start,
   input wire logic read_event,
   input wire logic noread_event,
   input wire logic missed_trigger,
   input wire logic ext_strobe,
   input wire logic ring_light,
   input wire logic [31:0] view_window
);
   logic [2:0] mode;
   logic [1:0] ext_sel;
   logic [1:0] ring_sel;
   // mirror of software settings; host-channel mode writes are not seen here
   always_ff @(posedge clk) begin
      if (reset) begin
         mode <= 3'h1;
         ext_sel <= 2'h2;
         ring_sel <= 2'h2;
      end else if (reg_write && reg_addr == 4'h0 && reg_wdata[2:0] <= 3'h4) begin
         mode <= reg_wdata[2:0];
      end else if (reg_write && reg_addr == 4'h1) begin
         ext_sel <= reg_wdata[1:0];
         ring_sel <= reg_wdata[3:2];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // settings are compared two cycles late since the light outputs are registered
   chk_rdata_slot: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   chk_scan_after: assert property ($fell(capture_active) && mode != 3'h2
      |-> ##[0:2] scan_start)
      else $error("capture end without scan start");
   chk_start_pulse: assert property (scan_start |=> !scan_start)
      else $error("scan start longer than a pulse");
   chk_read_after: assert property (scan_done && scan_found && mode != 3'h0
      |-> ##[1:3] read_event)
      else $error("found code not reported");
   chk_noread_after: assert property (scan_done && !scan_found && mode != 3'h0
      && mode != 3'h2 |-> ##[1:4] noread_event)
      else $error("failed scan without no-read");
   chk_missed_hold: assert property (missed_trigger && !(reg_write && reg_addr == 4'h7
      && reg_wdata[0]) |=> missed_trigger)
      else $error("missed trigger dropped without clear");
   chk_view_full: assert property (reg_write && reg_addr == 4'h7 && reg_wdata[1]
      |=> view_window == 32'hffffffff)
      else $error("view not restored");
   chk_ext_on: assert property (ext_sel == 2'h1 && $past(ext_sel, 2) == 2'h1 |-> ext_strobe)
      else $error("strobe not on");
   chk_ring_expo: assert property (ring_sel == 2'h2 && $past(ring_sel, 2) == 2'h2 && ring_light
      |-> capture_active || $past(capture_active))
      else $error("ring light outside capture");
   chk_ie_only: assert property (mode == 3'h4 && $past(mode, 2) == 3'h4 && !ie_trigger
      && !capture_active |=> !capture_active)
      else $error("capture from a refused source");
endmodule : acq_trigger_ctrl_chk
bind acq_trigger_ctrl acq_trigger_ctrl_chk u_chk (.clk, .reset, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .ie_trigger, .scan_done, .scan_found, .capture_active,
   .scan_start, .read_event, .noread_event, .missed_trigger, .ext_strobe, .ring_light,
   .view_window);
`default_nettype wire

// >>> verif/scan_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// decoder stand-in: answers each scan after lat cycles
module scan_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic scan_start,
   input wire logic find,
   input wire logic [5:0] lat,
   input wire logic [31:0] code,
   output logic scan_done,
   output logic scan_found,
   output logic [31:0] scan_code
);
   logic [5:0] cnt;
   logic hold;
   // code stands in the answer cycle and the next, then flips to its complement every cycle
   always_ff @(posedge clk) begin
      scan_done <= 1'h0;
      scan_found <= 1'h0;
      hold <= 1'h0;
      if (!hold)
         scan_code <= ~scan_code;
      if (scan_start)
         cnt <= lat;
      else if (cnt != 6'h0)
         cnt <= cnt - 6'h1;
      if (cnt == 6'h1 && !scan_start) begin
         scan_done <= 1'h1;
         scan_found <= find;
         scan_code <= code;
         hold <= 1'h1;
      end
      if (reset) begin
         cnt <= 6'h0;
         scan_code <= 32'h0;
      end
   end
endmodule : scan_model
`default_nettype wire

// >>> verif/acq_trigger_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// sequencer bench
module acq_trigger_ctrl_bench;
   logic clk, reset, reg_write, reg_read, ext_trigger, host_trigger, host_mode_write;
   logic ie_trigger, scan_done, scan_found, capture_active, scan_start, read_event;
   logic noread_event, missed_trigger, display_hold, ext_strobe, ring_light, find;
   logic [2:0] host_mode;
   logic [3:0] reg_addr;
   logic [5:0] lat;
   logic [31:0] reg_wdata, reg_rdata, scan_code, report_code, view_window, code, rdv;
   int fail_count, comparisons;
   // rows: write flag, address, write data, expected read-back
   logic [68:0] rows [13] = '{{1'h0, 4'h2, 32'h0, 32'h3e8}, {1'h0, 4'h3, 32'h0, 32'h1},
      {1'h0, 4'h4, 32'h0, 32'h0}, {1'h0, 4'h5, 32'h0, 32'h64}, {1'h0, 4'h6, 32'h0, 32'h1},
      {1'h0, 4'h9, 32'h0, 32'hffffffff}, {1'h0, 4'ha, 32'h0, 32'h0},
      {1'h1, 4'h4, 32'hfff, 32'he10}, {1'h1, 4'h4, 32'h0, 32'h0}, {1'h1, 4'h9, 32'hf, 32'hf},
      {1'h1, 4'h1, 32'h5, 32'h5}, {1'h1, 4'h5, 32'h1, 32'h1}, {1'h1, 4'h0, 32'h9, 32'h9}};

   acq_trigger_ctrl u_acq_trigger_ctrl (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .ext_trigger(ext_trigger), .host_trigger(host_trigger),
      .host_mode_write(host_mode_write), .host_mode(host_mode), .ie_trigger(ie_trigger),
      .scan_done(scan_done), .scan_found(scan_found), .scan_code(scan_code),
      .capture_active(capture_active), .scan_start(scan_start), .read_event(read_event),
      .noread_event(noread_event), .report_code(report_code),
      .missed_trigger(missed_trigger), .display_hold(display_hold),
      .ext_strobe(ext_strobe), .ring_light(ring_light), .view_window(view_window));
   scan_model u_scan_model (.clk(clk), .reset(reset), .scan_start(scan_start), .find(find),
      .lat(lat), .code(code), .scan_done(scan_done), .scan_found(scan_found),
      .scan_code(scan_code));

   // ============================================================
   // helpers
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge clk);
      reg_write <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge clk);
      reg_read <= 1'h0;
      @(negedge clk);
      rdv = reg_rdata;
   endtask : rd
   task automatic hm(input logic [2:0] m);
      @(posedge clk);
      host_mode <= m;
      host_mode_write <= 1'h1;
      @(posedge clk);
      host_mode_write <= 1'h0;
   endtask : hm
   function automatic logic sig(input int k);
      case (k)
         0: return capture_active;
         1: return scan_start;
         2: return noread_event;
         default: return read_event;
      endcase
   endfunction : sig
   // bounded wait, sampled mid-cycle so one-cycle pulses are caught
   task automatic wait_on(input int k, input int lim);
      int n;
      n = 0;
      @(negedge clk);
      while (sig(k) !== 1'h1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk("handshake", 32'h1, {31'h0, sig(k)});
   endtask : wait_on

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   // the two captures end on the first two millisecond ticks, near cycle 100000
   initial begin
      repeat (105000) @(posedge clk);
      fail_count++;
      $display("unexpected watchdog: expected finish seen hang");
      summarize();
   end

   // ============================================================
   // main sequence
   initial begin
      {reset, reg_write, reg_read, ext_trigger, host_trigger, host_mode_write} = 6'h20;
      {ie_trigger, find, host_mode, reg_addr, reg_wdata} = 41'h0;
      lat = 6'h28;
      code = 32'h0;
      repeat (20) @(posedge clk);
      reset <= 1'h0;
      for (int i = 0; i < 13; i++) begin
         if (rows[i][68])
            wr(rows[i][67:64], rows[i][63:32]);
         rd(rows[i][67:64]);
         chk("register", rows[i][31:0], rdv);
      end
      // lights forced on, then off, then exposure based
      chk("ext_strobe", 32'h1, {31'h0, ext_strobe});
      chk("ring_light", 32'h1, {31'h0, ring_light});
      wr(4'h1, 32'h0);
      repeat (2) @(negedge clk);
      chk("ext_strobe", 32'h0, {31'h0, ext_strobe});
      chk("ring_light", 32'h0, {31'h0, ring_light});
      wr(4'h1, 32'ha);
      wr(4'h7, 32'h2);
      repeat (2) @(negedge clk);
      chk("view_window", 32'hffffffff, view_window);
      hm(3'h2);
      hm(3'h7);
      rd(4'h0);
      chk("mode", 32'h2, {29'h0, rdv[2:0]});
      wr(4'h0, 32'h9);
      // single shot: rising edge, retrigger while busy, scan without a find
      @(posedge clk);
      ext_trigger <= 1'h1;
      wait_on(0, 10);
      @(negedge clk);
      chk("ext_strobe", 32'h1, {31'h0, ext_strobe});
      chk("ring_light", 32'h1, {31'h0, ring_light});
      @(posedge clk);
      ext_trigger <= 1'h0;
      tick(2);
      ext_trigger <= 1'h1;
      tick(4);
      @(negedge clk);
      chk("missed_trigger", 32'h1, {31'h0, missed_trigger});
      wait_on(1, 60000);
      wait_on(2, 60);
      rd(4'h6);
      chk("status", 32'h3, {30'h0, rdv[7:6]});
      chk("ext_strobe", 32'h0, {31'h0, ext_strobe});
      chk("ring_light", 32'h0, {31'h0, ring_light});
      wr(4'h7, 32'h1);
      repeat (2) @(negedge clk);
      chk("missed_trigger", 32'h0, {31'h0, missed_trigger});
      // falling edge is ignored under rising polarity
      @(posedge clk);
      ext_trigger <= 1'h0;
      tick(6);
      @(negedge clk);
      chk("capture_active", 32'h0, {31'h0, capture_active});
      // gated: capture on the active edge, no-read once the input drops
      wr(4'h0, 32'ha);
      @(posedge clk);
      ext_trigger <= 1'h1;
      wait_on(0, 3);
      @(posedge clk);
      ext_trigger <= 1'h0;
      wait_on(2, 4);
      // industrial ethernet only, while the failed image is still on hold
      wr(4'h0, 32'h4);
      find <= 1'h1;
      code <= 32'h5a5a0001;
      lat <= 6'h3;
      @(posedge clk);
      host_trigger <= 1'h1;
      ext_trigger <= 1'h1;
      @(posedge clk);
      host_trigger <= 1'h0;
      ext_trigger <= 1'h0;
      tick(6);
      @(negedge clk);
      chk("capture_active", 32'h0, {31'h0, capture_active});
      chk("display_hold", 32'h1, {31'h0, display_hold});
      @(posedge clk);
      ie_trigger <= 1'h1;
      @(posedge clk);
      ie_trigger <= 1'h0;
      wait_on(0, 3);
      wait_on(3, 60000);
      tick(2);
      @(negedge clk);
      chk("report_code", 32'h5a5a0001, report_code);
      // mid-run reset: full view back, hold and flags clear
      wr(4'h9, 32'h0);
      reset <= 1'h1;
      tick(2);
      reset <= 1'h0;
      rd(4'h6);
      chk("status", 32'h1, rdv);
      chk("view_window", 32'hffffffff, view_window);
      summarize();
   end
endmodule : acq_trigger_ctrl_bench
`default_nettype wire
